// ===== rtl/sie_pkg.sv
// Package of encodings, field positions and phase codes for the subset instruction executor.
package sie_pkg;
  localparam logic [2:0] SIE_CALL_TOP = 3'h7;
  localparam logic [6:0] SIE_CLR_TOP = 7'h14;
  localparam logic [6:0] SIE_COM_TOP = 7'h09;
  localparam logic [2:0] SIE_MOVP_TOP = 3'h2;
  localparam logic [7:0] SIE_MOVW_TOP = 8'h01;
  localparam logic [15:0] SIE_WDT_OP = 16'h0004;
  localparam int SIE_LIT_W = 13;
  localparam int SIE_SEL_BIT = 8;
  localparam int SIE_P_W = 5;
  localparam logic [7:0] SIE_ZERO = 8'h00;
  localparam logic [15:0] SIE_PC_RST = 16'h0000;
  localparam logic [7:0] SIE_LATCH_RST = 8'h00;
  typedef enum logic [1:0] {
    SIE_Q1 = 2'b00,
    SIE_Q2 = 2'b01,
    SIE_Q3 = 2'b10,
    SIE_Q4 = 2'b11
  } sie_phase_t;
endpackage

// ===== rtl/sie_executor.sv
// Decoder and executor for six instructions of an 8-bit core, four phases per cycle.
module sie_executor
  import sie_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Instruction fetch.
  input wire logic [15:0] instr,
  output logic instr_taken,
  output logic [1:0] phase,
  // Program counter and return stack.
  output logic [15:0] pc,
  output logic [7:0] program_counter_latch,
  output logic stack_push,
  output logic [15:0] return_stack_top,
  // Data memory file; indirect addresses are resolved outside.
  output logic [7:0] file_raddr,
  output logic file_rd,
  input wire logic [7:0] file_rdata,
  output logic [7:0] file_waddr,
  output logic [7:0] file_wdata,
  output logic file_we,
  // Working register, flags and watchdog.
  output logic [7:0] working_register,
  output logic zero_flag,
  output logic timeout_flag,
  output logic power_down_flag,
  output logic wdt_clear,
  output logic other_op
);

  ////////////////////////////////////////////////////////////////////////
  // Phase and instruction holding.
  sie_phase_t ph_r;
  logic [15:0] ir_r;
  logic fnop_r;
  logic [7:0] opnd_r;
  logic [15:0] pc_r;
  logic [7:0] latch_r;
  logic [15:0] tos_r;
  logic push_r;
  logic [7:0] w_r;
  logic z_r, to_r, pd_r, wdtc_r;
  logic [7:0] fwa_r, fwd_r;
  logic fwe_r;

  // Opcode match wires; a forced no-op suppresses every match.
  wire is_call = !fnop_r && ir_r[15:13] == SIE_CALL_TOP;
  wire is_clr = !fnop_r && ir_r[15:9] == SIE_CLR_TOP;
  wire is_wdt = !fnop_r && ir_r == SIE_WDT_OP;
  wire is_com = !fnop_r && ir_r[15:9] == SIE_COM_TOP;
  wire is_movp = !fnop_r && ir_r[15:13] == SIE_MOVP_TOP;
  wire is_movw = !fnop_r && ir_r[15:8] == SIE_MOVW_TOP;
  wire known = is_call | is_clr | is_wdt | is_com | is_movp | is_movw;
  wire [12:0] lit = ir_r[SIE_LIT_W-1:0];
  wire sel_bit = ir_r[SIE_SEL_BIT];
  wire [7:0] f_addr = ir_r[7:0];
  wire [7:0] p_addr = {3'h0, ir_r[12:8]};
  // The read address is the 5-bit source field for a move to file, otherwise the 8-bit file field.
  wire [7:0] rd_addr = is_movp ? p_addr : f_addr;
  wire [7:0] com_val = ~opnd_r;

  // Phase counter.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ph_r <= SIE_Q1;
    end else begin
      ph_r <= sie_phase_t'(ph_r + 2'h1);
    end
  end

  // Fetch latch: an instruction is taken at the end of Q4; after a call the next one is dropped.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ir_r <= 16'h0000;
      fnop_r <= 1'b1;
    end else if (ph_r == SIE_Q4) begin
      ir_r <= instr;
      fnop_r <= is_call;
    end
  end

  // Operand read in Q2.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      opnd_r <= SIE_ZERO;
    end else if (ph_r == SIE_Q2) begin
      opnd_r <= file_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Call: push in Q2, then load PC and latch in Q3, so the push is first.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pc_r <= SIE_PC_RST;
      latch_r <= SIE_LATCH_RST;
      tos_r <= SIE_PC_RST;
      push_r <= 1'b0;
    end else begin
      push_r <= is_call && ph_r == SIE_Q2;
      if (is_call && ph_r == SIE_Q2) begin
        tos_r <= pc_r + 16'h0001;
      end
      if (is_call && ph_r == SIE_Q3) begin
        pc_r <= {pc_r[15:13], lit};
        latch_r <= {pc_r[15:13], lit[12:8]};
      end else if (ph_r == SIE_Q4 && !is_call) begin
        pc_r <= pc_r + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Execute results are written at the end of Q3; other opcodes leave all state alone.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      w_r <= SIE_ZERO;
      z_r <= 1'b0;
      to_r <= 1'b1;
      pd_r <= 1'b1;
      wdtc_r <= 1'b0;
      fwa_r <= SIE_ZERO;
      fwd_r <= SIE_ZERO;
      fwe_r <= 1'b0;
    end else begin
      fwe_r <= 1'b0;
      wdtc_r <= 1'b0;
      if (ph_r == SIE_Q3) begin
        if (is_clr) begin
          fwa_r <= f_addr;
          fwd_r <= SIE_ZERO;
          fwe_r <= 1'b1;
          if (!sel_bit) begin
            w_r <= SIE_ZERO;
          end
        end
        if (is_com) begin
          z_r <= com_val == SIE_ZERO;
          if (sel_bit) begin
            fwa_r <= f_addr;
            fwd_r <= com_val;
            fwe_r <= 1'b1;
          end else begin
            w_r <= com_val;
          end
        end
        if (is_movp) begin
          fwa_r <= f_addr;
          fwd_r <= opnd_r;
          fwe_r <= 1'b1;
          z_r <= opnd_r == SIE_ZERO;
        end
        if (is_movw) begin
          fwa_r <= f_addr;
          fwd_r <= w_r;
          fwe_r <= 1'b1;
        end
        if (is_wdt) begin
          wdtc_r <= 1'b1;
          to_r <= 1'b1;
          pd_r <= 1'b1;
        end
      end
    end
  end

  // Output drive.
  assign instr_taken = ph_r == SIE_Q4;
  assign phase = ph_r;
  assign pc = pc_r;
  assign program_counter_latch = latch_r;
  assign stack_push = push_r;
  assign return_stack_top = tos_r;
  assign file_raddr = rd_addr;
  assign file_rd = ph_r == SIE_Q2 && (is_com | is_movp);
  assign file_waddr = fwa_r;
  assign file_wdata = fwd_r;
  assign file_we = fwe_r;
  assign working_register = w_r;
  assign zero_flag = z_r;
  assign timeout_flag = to_r;
  assign power_down_flag = pd_r;
  assign wdt_clear = wdtc_r;
  assign other_op = ph_r == SIE_Q1 && !fnop_r && !known;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_call_pc;
    @(posedge clk_sys) disable iff (srst)
    (is_call && ph_r == SIE_Q3) |=> pc_r[12:0] == $past(lit) && pc_r[15:13] == $past(pc_r[15:13]);
  endproperty
  a_call_pc: assert property (p_call_pc) else $error("call target wrong");

  property p_push_first;
    @(posedge clk_sys) disable iff (srst)
    (is_call && ph_r == SIE_Q2) |=> push_r && tos_r == $past(pc_r) + 16'h0001
      ##1 pc_r[12:0] == lit;
  endproperty
  a_push_first: assert property (p_push_first) else $error("push not before pc load");

  property p_latch;
    @(posedge clk_sys) disable iff (srst)
    (is_call && ph_r == SIE_Q3) |=> latch_r == {pc_r[15:13], pc_r[12:8]};
  endproperty
  a_latch: assert property (p_latch) else $error("latch copy wrong");

  property p_fnop;
    @(posedge clk_sys) disable iff (srst)
    (is_call && ph_r == SIE_Q4) |=> (fnop_r && !known) [*4];
  endproperty
  a_fnop: assert property (p_fnop) else $error("no forced no-op after call");

  property p_clr;
    @(posedge clk_sys) disable iff (srst)
    (is_clr && ph_r == SIE_Q3) |=> fwe_r && fwd_r == SIE_ZERO && (sel_bit || w_r == SIE_ZERO);
  endproperty
  a_clr: assert property (p_clr) else $error("clear wrong");

  property p_wdt;
    @(posedge clk_sys) disable iff (srst)
    (is_wdt && ph_r == SIE_Q3) |=> wdtc_r && to_r && pd_r ##1 !wdtc_r;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog clear wrong");

  property p_com;
    @(posedge clk_sys) disable iff (srst)
    (is_com && ph_r == SIE_Q3) |=> z_r == ($past(opnd_r) == 8'hFF);
  endproperty
  a_com: assert property (p_com) else $error("complement zero flag wrong");

  property p_movw;
    @(posedge clk_sys) disable iff (srst)
    (is_movw && ph_r == SIE_Q3) |=> fwe_r && fwd_r == w_r && z_r == $past(z_r);
  endproperty
  a_movw: assert property (p_movw) else $error("store wrong");

  property p_other;
    @(posedge clk_sys) disable iff (srst)
    (!known && ph_r == SIE_Q3) |=> !fwe_r && w_r == $past(w_r) && !wdtc_r;
  endproperty
  a_other: assert property (p_other) else $error("unknown opcode changed state");

  // Phase, strobe and per-opcode checks; the unknown-opcode frame must stay quiet as well.
  property p_phase_step;
    @(posedge clk_sys) disable iff (srst)
    1'b1 |=> ph_r == sie_phase_t'($past(ph_r) + 2'h1);
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase did not advance");

  property p_clr_target;
    @(posedge clk_sys) disable iff (srst)
    (is_clr && ph_r == SIE_Q3) |=> fwa_r == f_addr && z_r == $past(z_r);
  endproperty
  a_clr_target: assert property (p_clr_target) else $error("clear target or flag wrong");

  property p_clr_keep_w;
    @(posedge clk_sys) disable iff (srst)
    (is_clr && sel_bit && ph_r == SIE_Q3) |=> w_r == $past(w_r);
  endproperty
  a_clr_keep_w: assert property (p_clr_keep_w) else $error("clear touched working reg");

  property p_com_dest;
    @(posedge clk_sys) disable iff (srst)
    (is_com && sel_bit && ph_r == SIE_Q3) |=> fwe_r && fwa_r == f_addr
      && fwd_r == ~$past(opnd_r);
  endproperty
  a_com_dest: assert property (p_com_dest) else $error("complement write-back wrong");

  property p_com_w;
    @(posedge clk_sys) disable iff (srst)
    (is_com && !sel_bit && ph_r == SIE_Q3) |=> !fwe_r && w_r == ~$past(opnd_r);
  endproperty
  a_com_w: assert property (p_com_w) else $error("complement to working reg wrong");

  property p_movp;
    @(posedge clk_sys) disable iff (srst)
    (is_movp && ph_r == SIE_Q3) |=> fwe_r && fwa_r == f_addr && fwd_r == $past(opnd_r)
      && z_r == ($past(opnd_r) == SIE_ZERO);
  endproperty
  a_movp: assert property (p_movp) else $error("move to file wrong");

  property p_movp_read;
    @(posedge clk_sys) disable iff (srst)
    (is_movp && ph_r == SIE_Q2) |-> file_rd && file_raddr == p_addr;
  endproperty
  a_movp_read: assert property (p_movp_read) else $error("move source read wrong");

  property p_wdt_phase;
    @(posedge clk_sys) disable iff (srst)
    wdtc_r |-> ph_r == SIE_Q4;
  endproperty
  a_wdt_phase: assert property (p_wdt_phase) else $error("watchdog pulse out of phase");

  property p_wdt_quiet;
    @(posedge clk_sys) disable iff (srst)
    (is_wdt && ph_r == SIE_Q3) |=> !fwe_r && w_r == $past(w_r) && z_r == $past(z_r);
  endproperty
  a_wdt_quiet: assert property (p_wdt_quiet) else $error("watchdog clear wrote data");

  property p_call_flags;
    @(posedge clk_sys) disable iff (srst)
    (is_call && ph_r == SIE_Q3) |=> !fwe_r && z_r == $past(z_r) && w_r == $past(w_r);
  endproperty
  a_call_flags: assert property (p_call_flags) else $error("call changed data state");

  property p_fnop_pc;
    @(posedge clk_sys) disable iff (srst)
    (is_call && ph_r == SIE_Q4) |=> pc_r == $past(pc_r);
  endproperty
  a_fnop_pc: assert property (p_fnop_pc) else $error("call target stepped early");

  property p_push_pulse;
    @(posedge clk_sys) disable iff (srst)
    push_r |=> !push_r;
  endproperty
  a_push_pulse: assert property (p_push_pulse) else $error("push strobe too long");

  property p_we_q4;
    @(posedge clk_sys) disable iff (srst)
    fwe_r |-> ph_r == SIE_Q4;
  endproperty
  a_we_q4: assert property (p_we_q4) else $error("file write out of phase");

  property p_read_q2;
    @(posedge clk_sys) disable iff (srst)
    file_rd |-> ph_r == SIE_Q2;
  endproperty
  a_read_q2: assert property (p_read_q2) else $error("file read out of phase");

  property p_movw_target;
    @(posedge clk_sys) disable iff (srst)
    (is_movw && ph_r == SIE_Q3) |=> fwa_r == f_addr && w_r == $past(w_r);
  endproperty
  a_movw_target: assert property (p_movw_target) else $error("store target wrong");

  property p_other_pulse;
    @(posedge clk_sys) disable iff (srst)
    other_op |-> ##3 !fwe_r && !wdtc_r;
  endproperty
  a_other_pulse: assert property (p_other_pulse) else $error("unknown opcode wrote");

  c_call: cover property (@(posedge clk_sys) disable iff (srst) is_call && ph_r == SIE_Q3);
  c_movp: cover property (@(posedge clk_sys) disable iff (srst) is_movp && ph_r == SIE_Q3);
  c_com: cover property (@(posedge clk_sys) disable iff (srst)
    is_com && !sel_bit && ph_r == SIE_Q3);
  c_wdt: cover property (@(posedge clk_sys) disable iff (srst) is_wdt && ph_r == SIE_Q3);
  c_clr_w: cover property (@(posedge clk_sys) disable iff (srst)
    is_clr && !sel_bit && ph_r == SIE_Q3);

endmodule

// ===== tb/sie_file_model.sv
// Behavioural data memory that answers the executor's file port.
module sie_file_model (
  // Clock.
  input wire logic clk_sys,
  // Read port.
  input wire logic [7:0] file_raddr,
  input wire logic file_rd,
  output logic [7:0] file_rdata,
  // Write port.
  input wire logic [7:0] file_waddr,
  input wire logic [7:0] file_wdata,
  input wire logic file_we
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  // Outside a read the data is inverted, so a late sample cannot match by luck.
  assign file_rdata = file_rd ? mem[file_raddr] : ~mem[file_raddr];
  // Writes land at the edge that closes the write phase.
  always @(posedge clk_sys) begin
    if (file_we === 1'b1) begin
      mem[file_waddr] <= file_wdata;
    end
  end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the subset instruction executor.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [15:0] instr = 16'h0000;
  logic instr_taken, stack_push, file_rd, file_we, zero_flag, timeout_flag;
  logic power_down_flag, wdt_clear, other_op;
  logic [1:0] phase;
  logic [15:0] pc, return_stack_top, p;
  logic [7:0] program_counter_latch, file_raddr, file_rdata, file_waddr;
  logic [7:0] file_wdata, working_register;
  int fail_count = 0;
  int comparisons = 0;
  int wdt_n = 0;
  sie_executor sie_executor_i (.*);
  sie_file_model sie_file_model_i (.*);
  always #2 clk_sys = ~clk_sys;
  // Counts watchdog clear pulses; one per clear instruction is expected.
  always @(posedge clk_sys) begin
    if (wdt_clear === 1'b1) wdt_n++;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Presents a word for exactly one fetch, then falls back to an idle word.
  task automatic issue(input logic [15:0] w);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (phase !== 2'h2 && n < 8) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 8) chk(16'(phase), 16'h0002);
    @(posedge clk_sys) instr <= w;
    @(posedge clk_sys) instr <= 16'h0000;
  endtask
  // Lets the executing frame finish before anything is looked at.
  task automatic settle;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(phase, 2'h0);
    chk(pc, 16'h0000);
    chk(program_counter_latch, 8'h00);
    chk(working_register, 8'h00);
    chk(timeout_flag, 1'b1);
    chk(power_down_flag, 1'b1);
  endtask
  task automatic t_complement;
    sie_file_model_i.mem[8'h40] = 8'h13;
    sie_file_model_i.mem[8'h41] = 8'hFF;
    issue(16'h1240);
    settle();
    chk(working_register, 8'hEC);
    chk(sie_file_model_i.mem[8'h40], 8'h13);
    chk(zero_flag, 1'b0);
    issue(16'h1341);
    settle();
    chk(sie_file_model_i.mem[8'h41], 8'h00);
    chk(zero_flag, 1'b1);
    chk(working_register, 8'hEC);
  endtask
  task automatic t_moves;
    issue(16'h0150);
    settle();
    chk(sie_file_model_i.mem[8'h50], 8'hEC);
    chk(zero_flag, 1'b1);
    sie_file_model_i.mem[8'h1F] = 8'h5A;
    issue(16'h5FFF);
    @(negedge clk_sys);
    @(negedge clk_sys);
    chk(file_rd, 1'b1);
    chk(file_raddr, 8'h1F);
    settle();
    chk(sie_file_model_i.mem[8'hFF], 8'h5A);
    chk(zero_flag, 1'b0);
  endtask
  task automatic t_clear_keep;
    issue(16'h2940);
    settle();
    chk(sie_file_model_i.mem[8'h40], 8'h00);
    chk(working_register, 8'hEC);
    chk(zero_flag, 1'b0);
  endtask
  // Unknown opcode and watchdog clear: state must hold, one clear pulse.
  task automatic t_other_wdt;
    int n;
    sie_file_model_i.mem[8'h23] = 8'h77;
    issue(16'hC123);
    @(negedge clk_sys);
    chk(other_op, 1'b1);
    settle();
    chk(sie_file_model_i.mem[8'h23], 8'h77);
    chk(working_register, 8'hEC);
    n = wdt_n;
    issue(16'h0004);
    @(negedge clk_sys);
    chk(other_op, 1'b0);
    settle();
    chk(16'(wdt_n - n), 16'h0001);
    chk(timeout_flag, 1'b1);
    chk(power_down_flag, 1'b1);
  endtask
  // The word fetched behind a call must be discarded.
  task automatic t_call;
    int n;
    sie_file_model_i.mem[8'h60] = 8'h99;
    issue(16'hF234);
    n = 0;
    while (stack_push !== 1'b1 && n < 8) begin
      @(negedge clk_sys);
      n++;
    end
    chk(stack_push, 1'b1);
    p = pc;
    chk(return_stack_top, p + 16'h0001);
    @(posedge clk_sys) instr <= 16'h2860;
    @(negedge clk_sys);
    chk(instr_taken, 1'b1);
    chk(pc, {p[15:13], 13'h1234});
    chk(program_counter_latch, {p[15:13], 5'h12});
    @(posedge clk_sys) instr <= 16'h0000;
    settle();
    chk(sie_file_model_i.mem[8'h60], 8'h99);
    chk(working_register, 8'hEC);
    chk(zero_flag, 1'b0);
    issue(16'h2860);
    settle();
    chk(sie_file_model_i.mem[8'h60], 8'h00);
    chk(working_register, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence, with a watchdog far beyond the roughly one hundred cycles used.
  initial begin
    repeat (15) @(posedge clk_sys);
    @(negedge clk_sys);
    t_reset();
    @(posedge clk_sys) srst <= 1'b0;
    t_complement();
    t_moves();
    t_clear_keep();
    t_other_wdt();
    t_call();
    print_verdict();
  end
  initial begin
    #20000;
    fail_count++;
    print_verdict();
  end
endmodule
